// *** design/iper_consts.svh ***
// Constants for the end-of-service and priority-rotation block.
`ifndef IPER_CONSTS_SVH
`define IPER_CONSTS_SVH
`define IPER_LEVELS 8
`define IPER_LVL_W 3
`define IPER_PTR_RESET 3'h7
`define IPER_ACK_PULSES 2
`define IPER_CMD_W 3
`define IPER_CMD_NONE 3'h0
`define IPER_CMD_NS_EOS 3'h1
`define IPER_CMD_SP_EOS 3'h2
`define IPER_CMD_NS_EOS_ROT 3'h3
`define IPER_CMD_SET_PRIO 3'h4
`define IPER_CMD_SP_EOS_ROT 3'h5
`define IPER_CMD_ROT_ON 3'h6
`define IPER_CMD_ROT_OFF 3'h7
`endif

// *** design/iper_pick.sv ***
// Picks the highest-ranked set bit of a mask relative to a lowest pointer.
`timescale 1ns/100ps
`include "iper_consts.svh"
module iper_pick #(
  parameter int LEVELS = `IPER_LEVELS,
  parameter int LW = `IPER_LVL_W
) (
  // Inputs.
  input wire logic [LEVELS-1:0] bits,
  input wire logic [LW-1:0] lowPtr,
  // Result.
  output logic found,
  output logic [LW-1:0] level
);
  // The highest level sits just above the lowest pointer on the ring.
  always_comb
  begin
    logic [LW-1:0] idx;
    found = 1'b0;
    level = '0;
    idx = '0;
    for (int k = LEVELS - 1; k >= 0; k--)
    begin
      idx = LW'(lowPtr + LW'(LEVELS - k));
      if (bits[idx] && !found)
      begin
        found = 1'b1;
        level = idx;
      end
    end
  end
endmodule

// *** design/iper_pkg.sv ***
// Types for the end-of-service and priority-rotation block.
package iper_pkg;
  typedef enum logic [1:0] {AckIdle, AckFirst, AckLast} iper_ack_t;
  typedef struct packed {
    logic [7:0] inService;
    logic [2:0] lowPtr;
    logic autoEos;
    logic rotAuto;
    iper_ack_t ack;
    logic [2:0] ackLevel;
    logic ackValid;
    logic [7:0] vector;
    logic intReq;
    logic ackPulseD;
  } iper_state_t;
endpackage

// *** design/iper_top.sv ***
// Top of the end-of-service and priority-rotation block.
`timescale 1ns/100ps
`include "iper_consts.svh"
module iper_top #(
  parameter int LEVELS = `IPER_LEVELS,
  parameter int LW = `IPER_LVL_W,
  parameter logic [7:0] VECTOR_BASE = 8'h00
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Requests and acknowledge.
  input wire logic [LEVELS-1:0] pendingRequestBits,
  input wire logic acknowledgePulse,
  // Commands.
  input wire logic cmdValid,
  input wire logic [`IPER_CMD_W-1:0] cmdCode,
  input wire logic [LW-1:0] cmdLevel,
  input wire logic autoEosMode,
  // Results.
  output logic intReq,
  output logic [7:0] vectorData,
  output logic vectorValid,
  output logic [LEVELS-1:0] inServiceBits,
  output logic [LW-1:0] lowestLevel
);
  logic rstSync1_q;
  logic rstSync2_q;
  iper_pkg::iper_state_t state_q;
  iper_pkg::iper_state_t state_d;
  logic reqFound;
  logic [LW-1:0] reqLevel;
  logic isFound;
  logic [LW-1:0] isLevel;
  logic ackFall;
  logic ackRise;
  logic ackMoves;
  logic cmdTaken;
  logic [LEVELS-1:0] levelWins;
  logic doNsEos;
  logic doSpEos;
  logic doNsRot;
  logic doSetPrio;
  logic doSpRot;
  logic doRotOn;
  logic doRotOff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  // Highest pending request and highest in-service bit on the ring.
  iper_pick #(.LEVELS(LEVELS), .LW(LW)) pickReq (
    .bits(pendingRequestBits),
    .lowPtr(state_q.lowPtr),
    .found(reqFound),
    .level(reqLevel)
  );
  iper_pick #(.LEVELS(LEVELS), .LW(LW)) pickIs (
    .bits(state_q.inService),
    .lowPtr(state_q.lowPtr),
    .found(isFound),
    .level(isLevel)
  );

  assign ackRise = acknowledgePulse && !state_q.ackPulseD;
  assign ackFall = !acknowledgePulse && state_q.ackPulseD;

  // Ring distance from the pointer; a larger rank means higher priority.
  function automatic logic [LW-1:0] rankOf(input logic [LW-1:0] lvl,
                                           input logic [LW-1:0] ptr);
    rankOf = LW'(ptr - lvl);
  endfunction

  // Each level asks whether it outranks every level in service.
  generate
    for (genvar g = 0; g < LEVELS; g++)
    begin : gLevel
      assign levelWins[g] = pendingRequestBits[g] && (!isFound
        || rankOf(LW'(g), state_q.lowPtr) > rankOf(isLevel, state_q.lowPtr));
    end
  endgenerate

  // A command that meets an acknowledge step is dropped, so the step wins.
  always_comb
  begin
    case (state_q.ack)
      iper_pkg::AckIdle:
      begin
        ackMoves = ackRise;
      end
      iper_pkg::AckFirst:
      begin
        ackMoves = ackRise;
      end
      iper_pkg::AckLast:
      begin
        ackMoves = ackFall;
      end
      default:
      begin
        ackMoves = 1'b1;
      end
    endcase
  end
  assign cmdTaken = cmdValid && !ackMoves;

  // One flag per accepted command code.
  always_comb
  begin
    doNsEos = 1'b0;
    doSpEos = 1'b0;
    doNsRot = 1'b0;
    doSetPrio = 1'b0;
    doSpRot = 1'b0;
    doRotOn = 1'b0;
    doRotOff = 1'b0;
    if (cmdTaken)
    begin
      case (cmdCode)
        `IPER_CMD_NS_EOS:
        begin
          doNsEos = 1'b1;
        end
        `IPER_CMD_SP_EOS:
        begin
          doSpEos = 1'b1;
        end
        `IPER_CMD_NS_EOS_ROT:
        begin
          doNsRot = 1'b1;
        end
        `IPER_CMD_SET_PRIO:
        begin
          doSetPrio = 1'b1;
        end
        `IPER_CMD_SP_EOS_ROT:
        begin
          doSpRot = 1'b1;
        end
        `IPER_CMD_ROT_ON:
        begin
          doRotOn = 1'b1;
        end
        `IPER_CMD_ROT_OFF:
        begin
          doRotOff = 1'b1;
        end
        default:
        begin
          doNsEos = 1'b0;
        end
      endcase
    end
  end

  always_comb
  begin
    state_d = state_q;
    state_d.ackPulseD = acknowledgePulse;
    state_d.autoEos = autoEosMode;
    // Priority is resolved only outside an acknowledge.
    if (state_q.ack == iper_pkg::AckIdle)
    begin
      state_d.intReq = |levelWins;
    end
    case (state_q.ack)
      iper_pkg::AckIdle:
      begin
        state_d.ackValid = 1'b0;
        if (ackRise)
        begin
          state_d.ack = iper_pkg::AckFirst;
          // Resolve and latch the winner at the first pulse.
          state_d.ackLevel = reqFound ? reqLevel : LW'(LEVELS - 1);
          state_d.inService[state_d.ackLevel] = 1'b1;
        end
      end
      iper_pkg::AckFirst:
      begin
        if (ackRise)
        begin
          state_d.ack = iper_pkg::AckLast;
          state_d.vector = VECTOR_BASE | {5'h00, state_q.ackLevel};
          state_d.ackValid = 1'b1;
        end
      end
      iper_pkg::AckLast:
      begin
        if (ackFall)
        begin
          state_d.ack = iper_pkg::AckIdle;
          state_d.ackValid = 1'b0;
          // Automatic clearing ends the acknowledge itself.
          if (state_q.autoEos)
          begin
            state_d.inService[state_q.ackLevel] = 1'b0;
            if (state_q.rotAuto)
            begin
              state_d.lowPtr = state_q.ackLevel;
            end
          end
        end
      end
      default:
      begin
        state_d.ack = iper_pkg::AckIdle;
      end
    endcase
    if (doNsEos && isFound)
    begin
      state_d.inService[isLevel] = 1'b0;
    end
    if (doSpEos)
    begin
      state_d.inService[cmdLevel] = 1'b0;
    end
    if (doNsRot && isFound)
    begin
      state_d.inService[isLevel] = 1'b0;
      state_d.lowPtr = isLevel;
    end
    if (doSetPrio)
    begin
      state_d.lowPtr = cmdLevel;
    end
    if (doSpRot)
    begin
      state_d.inService[cmdLevel] = 1'b0;
      state_d.lowPtr = cmdLevel;
    end
    if (doRotOn)
    begin
      state_d.rotAuto = 1'b1;
    end
    if (doRotOff)
    begin
      state_d.rotAuto = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
    begin
      state_q.inService <= 8'h00;
      state_q.lowPtr <= `IPER_PTR_RESET;
      state_q.autoEos <= 1'b0;
      state_q.rotAuto <= 1'b0;
      state_q.ack <= iper_pkg::AckIdle;
      state_q.ackLevel <= 3'h0;
      state_q.ackValid <= 1'b0;
      state_q.vector <= 8'h00;
      state_q.intReq <= 1'b0;
      state_q.ackPulseD <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign intReq = state_q.intReq;
  assign vectorData = state_q.vector;
  assign vectorValid = state_q.ackValid;
  assign inServiceBits = state_q.inService;
  assign lowestLevel = state_q.lowPtr;
endmodule

// *** verif/iper_chk.sv ***
// Assertion checker for the rotation block ports.
`timescale 1ns/100ps
module iper_chk #(
  parameter int LEVELS = 8,
  parameter int LW = 3
) (
  // Block inputs.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [LEVELS-1:0] pendingRequestBits,
  input wire logic acknowledgePulse,
  input wire logic cmdValid,
  input wire logic [2:0] cmdCode,
  input wire logic [LW-1:0] cmdLevel,
  input wire logic autoEosMode,
  // Block outputs.
  input wire logic intReq,
  input wire logic [7:0] vectorData,
  input wire logic vectorValid,
  input wire logic [LEVELS-1:0] inServiceBits,
  input wire logic [LW-1:0] lowestLevel
);
  logic [2:0] hs, hp;
  logic ph, rot, want;
  function automatic logic [2:0] top(logic [7:0] b, logic [2:0] p);
    top = 3'h7;
    for (int i = 8; i > 0; i--)
      if (b[3'(p + i)])
        top = 3'(p + i);
  endfunction
  assign hs = top(inServiceBits, lowestLevel);
  assign hp = top(pendingRequestBits, lowestLevel);
  assign want = |pendingRequestBits && (inServiceBits == 8'h00
    || 3'(lowestLevel - hp) > 3'(lowestLevel - hs));
  // Tracks which pulse of the pair is running and the rotation mode.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {ph, rot} <= 2'h0;
    else
    begin
      ph <= ph ^ $rose(acknowledgePulse);
      if (cmdValid && cmdCode[2:1] == 2'h3)
        rot <= !cmdCode[0];
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence quiet;
    !ph && !acknowledgePulse && !$past(acknowledgePulse)
      && $stable(pendingRequestBits) && $stable(inServiceBits)
      && $stable(lowestLevel);
  endsequence
  a_ack_claim: assert property (
    $rose(acknowledgePulse) && !ph |=> inServiceBits[$past(hp)])
    else $error("winner bit not set");
  a_vec_level: assert property (
    $rose(vectorValid) |-> inServiceBits[vectorData[2:0]])
    else $error("vector level not in service");
  a_auto_clear: assert property (
    $fell(vectorValid) && autoEosMode |-> !inServiceBits[vectorData[2:0]])
    else $error("automatic clear missing");
  a_auto_rot: assert property (
    $fell(vectorValid) && autoEosMode && rot |->
      lowestLevel == vectorData[2:0])
    else $error("automatic rotation missing");
  a_rot_eos: assert property (
    cmdValid && cmdCode == 3'h3 && |inServiceBits |=>
      lowestLevel == $past(hs) && !inServiceBits[$past(hs)])
    else $error("rotating clear wrong");
  a_set_prio: assert property (
    cmdValid && cmdCode == 3'h4 |=>
      lowestLevel == $past(cmdLevel) && $stable(inServiceBits))
    else $error("set priority wrong");
  a_spec_rot: assert property (
    cmdValid && cmdCode == 3'h5 |=>
      lowestLevel == $past(cmdLevel) && !inServiceBits[$past(cmdLevel)])
    else $error("specific rotation wrong");
  a_int_rank: assert property (
    quiet [*2] |-> intReq == want)
    else $error("request ranking wrong");
endmodule
bind iper_top iper_chk #(.LEVELS(LEVELS), .LW(LW)) u_chk (.*);

// *** verif/iper_host.sv ***
// Host model that runs acknowledge pairs and issues commands.
`timescale 1ns/100ps
module iper_host (
  // Clock.
  input wire logic clk,
  // Acknowledge and commands.
  output logic acknowledgePulse,
  output logic cmdValid,
  output logic [2:0] cmdCode,
  output logic [2:0] cmdLevel
);
  initial
  begin
    {acknowledgePulse, cmdValid, cmdCode, cmdLevel} = 8'h00;
  end
  // Acknowledges only when asked, so routines run with acknowledge held low.
  task automatic ack(input int w);
    repeat (2)
    begin
      acknowledgePulse <= 1'h1;
      repeat (w) @(posedge clk);
      acknowledgePulse <= 1'h0;
      repeat (w) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [2:0] l);
    cmdValid <= 1'h1;
    cmdCode <= c;
    cmdLevel <= l;
    @(posedge clk);
    cmdValid <= 1'h0;
    cmdCode <= ~c;
    cmdLevel <= ~l;
    repeat (2) @(posedge clk);
  endtask
endmodule

// *** verif/tb_irq_priority_eoi_rotation.sv ***
// Self-checking bench for the rotation block.
`timescale 1ns/100ps
module tb_irq_priority_eoi_rotation;
  logic clk, rst_n, autoEosMode, intReq, vectorValid, vvD, snapReq, rot;
  logic acknowledgePulse, cmdValid;
  logic [2:0] cmdCode, cmdLevel, lowestLevel, low, v;
  logic [7:0] pendingRequestBits, vectorData, inServiceBits, in_service_bits;
  logic [7:0] qv[$];
  logic [10:0] qs[$];
  int fails = 0, n_tests = 0, cyc = 0, seed = 32'h2586FCC7;
  iper_top dut_u (.*);
  iper_host host_u (.*);
  function automatic logic [2:0] top(logic [7:0] b);
    top = 3'h7;
    for (int i = 8; i > 0; i--)
      if (b[3'(low + i)])
        top = 3'(low + i);
  endfunction
  task automatic chk(string n, logic [10:0] e, logic [10:0] s);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic snap;
    qs.push_back({in_service_bits, low});
    snapReq <= 1'h1;
    @(posedge clk);
    snapReq <= 1'h0;
    @(posedge clk);
  endtask
  task automatic ack(logic [7:0] p, int w);
    pendingRequestBits <= p;
    @(posedge clk);
    v = top(p);
    qv.push_back({5'h00, v});
    in_service_bits[v] = !autoEosMode;
    if (autoEosMode && rot)
      low = v;
    host_u.ack(w);
    pendingRequestBits <= 8'h00;
    snap;
  endtask
  task automatic req(logic [7:0] p, logic e);
    pendingRequestBits <= p;
    repeat (3) @(posedge clk);
    chk("request", {10'h000, e}, {10'h000, intReq});
    pendingRequestBits <= 8'h00;
    @(posedge clk);
  endtask
  task automatic cmd(logic [2:0] c, logic [2:0] l);
    v = (c == 3'h2 || c == 3'h4 || c == 3'h5) ? l : top(in_service_bits);
    if (c == 3'h4 || c == 3'h5 || (c == 3'h3 && |in_service_bits))
      low = v;
    if (c != 3'h4 && c < 3'h6)
      in_service_bits[v] = 1'h0;
    if (c[2:1] == 2'h3)
      rot = !c[0];
    host_u.cmd(c, l);
    snap;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #2 clk = !clk;
  end
  always @(posedge clk)
  begin
    vvD <= vectorValid;
    cyc++;
    if (vectorValid && !vvD)
      chk("vector", {3'h0, qv.pop_front()}, {3'h0, vectorData});
    if (snapReq)
      chk("state", qs.pop_front(), {inServiceBits, lowestLevel});
    if (cyc == 3000)
    begin
      fails++;
      test_done;
    end
  end
  initial
  begin
    {rst_n, autoEosMode, snapReq, rot, in_service_bits} = 12'h000;
    pendingRequestBits = 8'h00;
    low = 3'h7;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    snap;
    ack(8'h08, 1);
    ack(8'h0A, 3);
    cmd(3'h1, 3'h0);
    req(8'h10, 1'h0);
    req(8'h01, 1'h1);
    cmd(3'h3, 3'h0);
    ack(8'h11, 2);
    $display("nesting done");
    cmd(3'h4, 3'h6);
    req(8'h20, 1'h0);
    req(8'h80, 1'h1);
    ack(8'h80, 1);
    cmd(3'h2, 3'h7);
    cmd(3'h5, 3'h4);
    cmd(3'h1, 3'h0);
    $display("commands done");
    autoEosMode <= 1'h1;
    @(posedge clk);
    ack(8'h40, 1);
    cmd(3'h6, 3'h0);
    repeat (6) ack(8'($random(seed)), 2);
    cmd(3'h7, 3'h0);
    ack(8'h02, 1);
    cmd(3'h4, 3'h2);
    $display("automatic done");
    test_done;
  end
endmodule
